/* dv/test_usb_frame_addr_pairing_regs.sv */
// test_usb_frame_addr_pairing_regs: self-checking bench for the frame, address, pairing slice.
// assumes: usb_fap_pkg and usb_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module test_usb_frame_addr_pairing_regs;
  import usb_fap_pkg::*;
  typedef struct packed {logic [10:0] f; logic [7:0] lo; logic [7:0] hi;} row_s;
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       sel_wr_i = 1'b0, data_wr_i = 1'b0, data_rd_i = 1'b0;
  logic [7:0] wdata_i = 8'h00, rdata_o, indirect_selector_o, rv;
  sof_s       sof_i;
  token_s     token_i;
  logic       addr_load_i, usb_reset_i, token_valid_i, acc, pin, pout, tin;
  logic [6:0] addr_value_i, function_address_o;
  logic [3:0] token_buf_o, b;
  logic [10:0] frame_count_o;
  int         miscompares = 0, samples_checked = 0;
  row_s       rows [5] = '{'{11'h7ff, 8'hff, 8'h07}, '{11'h555, 8'h55, 8'h05},
                           '{11'h2aa, 8'haa, 8'h02}, '{11'h123, 8'h23, 8'h01},
                           '{11'h000, 8'h00, 8'h00}};

  // =====================================================
  // clock and instances
  always #10 ref_clk_i = ~ref_clk_i;
  usb_frame_addr_pairing_regs usb_frame_addr_pairing_regs_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sel_wr_i(sel_wr_i), .data_wr_i(data_wr_i),
    .data_rd_i(data_rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .indirect_selector_o(indirect_selector_o), .sof_i(sof_i), .addr_load_i(addr_load_i),
    .addr_value_i(addr_value_i), .usb_reset_i(usb_reset_i), .token_valid_i(token_valid_i),
    .token_i(token_i), .token_accept_o(acc), .token_is_in_o(tin), .token_buf_o(token_buf_o),
    .frame_count_o(frame_count_o), .function_address_o(function_address_o),
    .pair_out_two_three_o(pout), .pair_in_two_three_o(pin));
  usb_host_model usb_host_model_i (
    .clk_i(ref_clk_i), .sof_o(sof_i), .addr_load_o(addr_load_i), .addr_value_o(addr_value_i),
    .usb_reset_o(usb_reset_i), .token_valid_o(token_valid_i), .token_o(token_i));

  // =====================================================
  // cpu window tasks: selector, then data port
  task automatic cpu_sel(input logic [7:0] v);
    @(posedge ref_clk_i);
    sel_wr_i <= 1'b1;
    wdata_i <= v;
    @(posedge ref_clk_i);
    sel_wr_i <= 1'b0;
  endtask
  task automatic cpu_wr(input logic [7:0] sa, input logic [7:0] v);
    cpu_sel(sa);
    data_wr_i <= 1'b1;
    wdata_i <= v;
    @(posedge ref_clk_i);
    data_wr_i <= 1'b0;
  endtask
  task automatic cpu_rd(input logic [7:0] sa, output logic [7:0] v);
    cpu_sel(sa);
    data_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    data_rd_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 v = rdata_o;
  endtask
  // token with the outcome seen in the cycle after it is taken
  task automatic tok(input logic is_in, input logic [3:0] ep, input logic [6:0] a);
    usb_host_model_i.send_token(is_in, ep, a);
    #1 b = acc ? token_buf_o : 4'hf;
  endtask

  // verdict
  task automatic close_out();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watchdog, far beyond the fewer than two hundred cycles the tests take
  initial
  begin
    #100000;
    miscompares++;
    close_out();
  end

  // =====================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    cpu_rd(8'h58, rv); `CHK("low rst", rv, 8'h00)
    cpu_rd(8'h59, rv); `CHK("high rst", rv, 8'h00)
    cpu_rd(8'h5b, rv); `CHK("addr rst", rv, 8'h00)
    cpu_rd(8'h5d, rv); `CHK("pair rst", rv, 8'h00)
    cpu_rd(8'h5a, rv); `CHK("unmapped", rv, 8'h00)
    `CHK("selector", indirect_selector_o, 8'h5a)
    // frame rows: load by start-of-frame, read both halves
    foreach (rows[i])
    begin
      usb_host_model_i.send_sof(rows[i].f);
      cpu_rd(8'h58, rv); `CHK("frame low", rv, rows[i].lo)
      cpu_rd(8'h59, rv); `CHK("frame high", rv, rows[i].hi)
      `CHK("frame out", frame_count_o, rows[i].f)
    end
    usb_host_model_i.send_sof(11'h6c3);
    cpu_wr(8'h58, 8'h55);
    cpu_rd(8'h58, rv); `CHK("low ro", rv, 8'hc3)
    cpu_rd(8'h59, rv); `CHK("high held", rv, 8'h06)
    // address: loaded by the host only
    usb_host_model_i.load_addr(7'h7f);
    cpu_wr(8'h5b, 8'h00);
    cpu_rd(8'h5b, rv); `CHK("addr ro", rv, 8'h7f)
    tok(1'b0, 4'h1, 7'h7e); `CHK("foreign tok", b, 4'hf)
    tok(1'b0, 4'h1, 7'h7f); `CHK("own tok", b, 4'h1)
    // pairing on both directions, reserved bits kept at zero
    cpu_wr(8'h5d, 8'h09);
    cpu_rd(8'h5d, rv); `CHK("pair rd", rv, 8'h09)
    for (int i = 0; i < 3; i++)
    begin
      tok(1'b0, 4'h2, 7'h7f); `CHK("out pair", b, (i == 1) ? 4'h3 : 4'h2)
    end
    for (int i = 0; i < 2; i++)
    begin
      tok(1'b1, 4'h3, 7'h7f); `CHK("in pair", b, i ? 4'h3 : 4'h2)
    end
    // back-to-back paired in tokens still alternate 2 then 3
    usb_host_model_i.send_token_twice(1'b1, 4'h3, 7'h7f);
    #1 `CHK("in back to back", token_buf_o, 4'h3)
    `CHK("in dir", tin, 1'b1)
    cpu_wr(8'h5d, 8'h08);
    cpu_rd(8'h5d, rv); `CHK("out only", rv, 8'h08)
    tok(1'b1, 4'h3, 7'h7f); `CHK("in free", b, 4'h3)
    tok(1'b0, 4'h3, 7'h7f); `CHK("out still", b, 4'h3)
    cpu_wr(8'h5d, 8'h00);
    tok(1'b0, 4'h3, 7'h7f); `CHK("out free", b, 4'h3)
    `CHK("out dir", tin, 1'b0)
    // bus reset drops the address back to zero
    usb_host_model_i.bus_reset();
    tok(1'b0, 4'h1, 7'h7f); `CHK("old addr", b, 4'hf)
    tok(1'b0, 4'h1, 7'h00); `CHK("zero addr", b, 4'h1)
    // reset in mid-run clears everything
    usb_host_model_i.load_addr(7'h15);
    cpu_wr(8'h5d, 8'h09);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 `CHK("rst state", {frame_count_o, function_address_o, pout, pin}, 20'h0)
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    cpu_rd(8'h5d, rv); `CHK("pair cleared", rv, 8'h00)
    close_out();
  end
endmodule // test_usb_frame_addr_pairing_regs
`default_nettype wire

/* dv/usb_host_model.sv */
// usb_host_model: bus-side stand-in for the host and the packet decoder.
// assumes: the bench calls one task at a time; every output changes at a rising edge.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
  import usb_fap_pkg::*;
(
  input  wire logic                clk_i,         // block clock
  output var  usb_fap_pkg::sof_s   sof_o,         // start-of-frame event
  output var  logic                addr_load_o,   // address load pulse
  output var  logic [6:0]          addr_value_o,  // address to load
  output var  logic                usb_reset_o,   // bus reset pulse
  output var  logic                token_valid_o, // token pulse
  output var  usb_fap_pkg::token_s token_o        // token fields
);
  // =====================================================
  // idle values at time zero
  initial
  begin
    sof_o = '0;
    addr_load_o = 1'b0;
    addr_value_o = 7'h00;
    usb_reset_o = 1'b0;
    token_valid_o = 1'b0;
    token_o = '0;
  end

  // one start-of-frame; released frame lines toggle so stale values never match
  task automatic send_sof(input logic [10:0] f);
    @(posedge clk_i);
    sof_o <= {1'b1, f};
    @(posedge clk_i);
    sof_o <= {1'b0, ~f};
  endtask

  // host assigns an address at the end of its set-address transfer
  task automatic load_addr(input logic [6:0] a);
    @(posedge clk_i);
    addr_load_o <= 1'b1;
    addr_value_o <= a;
    @(posedge clk_i);
    addr_load_o <= 1'b0;
    addr_value_o <= ~a;
  endtask

  // bus reset pulse
  task automatic bus_reset();
    @(posedge clk_i);
    usb_reset_o <= 1'b1;
    @(posedge clk_i);
    usb_reset_o <= 1'b0;
  endtask

  // two tokens on consecutive edges, back-to-back traffic
  task automatic send_token_twice(input logic is_in, input logic [3:0] ep, input logic [6:0] a);
    @(posedge clk_i);
    token_valid_o <= 1'b1;
    token_o <= {is_in, ep, a};
    repeat (2) @(posedge clk_i);
    token_valid_o <= 1'b0;
    token_o <= ~token_o;
  endtask

  // one token; returns at the edge that takes it
  task automatic send_token(input logic is_in, input logic [3:0] ep, input logic [6:0] a);
    @(posedge clk_i);
    token_valid_o <= 1'b1;
    token_o <= {is_in, ep, a};
    @(posedge clk_i);
    token_valid_o <= 1'b0;
    token_o <= ~token_o;
  endtask
endmodule // usb_host_model
`default_nettype wire

/* hw/pair_steer.sv */
// pair_steer: picks the buffer endpoint for one direction; when paired,
// endpoints 2 and 3 act as one ping-pong pair.
// assumes: synchronous active-low reset released by the parent.
`timescale 1ns/1ps
`default_nettype none
module pair_steer
  import usb_fap_pkg::*;
(
  input  wire logic             clk_i,      // block clock
  input  wire logic             rst_n_i,    // synced reset, active low
  input  wire logic             pair_en_i,  // pairing enabled
  input  wire logic             hit_i,      // accepted token this cycle
  input  wire logic [ENDP_W-1:0] endp_i,    // token endpoint number
  output logic      [ENDP_W-1:0] buf_o      // endpoint buffer to use
);

  logic pingpong_r;  // 0: buffer 2 next, 1: buffer 3 next
  logic in_pair;

  // token aims at either half of the pair
  assign in_pair = (endp_i == EP_PAIR_LO) || (endp_i == EP_PAIR_HI);

  // ===========================================================
  // ping-pong state, cleared while unpaired
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pingpong_r <= 1'b0;
    else if (!pair_en_i)
      pingpong_r <= 1'b0;
    else if (hit_i && in_pair)
      pingpong_r <= ~pingpong_r;
  end

  // paired tokens alternate buffers, others keep their own endpoint
  always_comb
  begin
    if (pair_en_i && in_pair)
      buf_o = pingpong_r ? EP_PAIR_HI : EP_PAIR_LO;
    else
      buf_o = endp_i;
  end

endmodule // pair_steer
`default_nettype wire

/* hw/usb_fap_pkg.sv */
// package: subaddress map, field layout, reset values and carriers
// for the frame count, function address and endpoint pairing slice.
// assumes: included first in compile order by every design file.
package usb_fap_pkg;

  // ===========================================================
  // indirect subaddresses
  localparam logic [7:0] SA_FRAME_LOW   = 8'h58;
  localparam logic [7:0] SA_FRAME_HIGH  = 8'h59;
  localparam logic [7:0] SA_FUNC_ADDR   = 8'h5b;
  localparam logic [7:0] SA_EP_PAIRING  = 8'h5d;

  // ===========================================================
  // field layout
  localparam int FRAME_LOW_W   = 8;
  localparam int FRAME_HIGH_W  = 3;
  localparam int FRAME_W       = FRAME_LOW_W + FRAME_HIGH_W;
  localparam int ADDR_W        = 7;
  localparam int ENDP_W        = 4;
  localparam int PAIR_OUT_BIT  = 3;
  localparam int PAIR_IN_BIT   = 0;

  // ===========================================================
  // reset values
  localparam logic [10:0] FRAME_RST     = 11'h000;
  localparam logic [6:0]  ADDR_RST      = 7'h00;
  localparam logic        PAIR_RST      = 1'b0;
  localparam logic [7:0]  RDATA_RST     = 8'h00;
  localparam logic [7:0]  SEL_RST       = 8'h00;

  // ===========================================================
  // paired endpoint numbers
  localparam logic [3:0]  EP_PAIR_LO    = 4'h2;
  localparam logic [3:0]  EP_PAIR_HI    = 4'h3;

  // token as seen from the packet decoder
  typedef struct packed {
    logic       is_in;    // 1: in token, 0: out token
    logic [3:0] endp;     // endpoint number
    logic [6:0] addr;     // function address field
  } token_s;

  // start-of-frame event
  typedef struct packed {
    logic        valid;   // one-cycle pulse
    logic [10:0] frame;   // frame number in the token
  } sof_s;

endpackage : usb_fap_pkg

/* hw/usb_frame_addr_pairing_regs.sv */
// usb_frame_addr_pairing_regs: frame count, function address and
// endpoint pairing subregisters behind an indirect selector/data window,
// plus token address filtering and pair buffer steering.
// assumes: cpu and packet decoder strobes are synchronous one-cycle pulses.
//
// Contract
// RL1: frame count loads the number from each start-of-frame, else holds.
// RL2: frame count is 11 bits: low byte, then high three bits in 2:0.
// RL3: frame low at subaddress 58h, frame high at 59h via data port.
// RL4: function address at 5Bh, pairing at 5Dh via selector and data port.
// RL5: function address is seven bits, readable, not writable by software.
// RL6: respond only to tokens whose address equals the stored address.
// RL7: pairing bit 3 pairs out endpoints 2 and 3, clear keeps independent.
// RL8: pairing bit 0 pairs in endpoints 2 and 3, clear keeps independent.
// RL9: software writes zeros to reserved bits; they read back as zero.
// RL10: reset clears frame count, address and both pairing controls.
`timescale 1ns/1ps
`default_nettype none
module usb_frame_addr_pairing_regs
  import usb_fap_pkg::*;
(
  input  wire logic                 ref_clk_i,      // 50 mhz clock
  input  wire logic                 rst_n_i,        // async reset, active low
  // cpu indirect window
  input  wire logic                 sel_wr_i,       // write indirect selector
  input  wire logic                 data_wr_i,      // write subdata port
  input  wire logic                 data_rd_i,      // read subdata port
  input  wire logic [7:0]           wdata_i,        // cpu write data
  output logic      [7:0]           rdata_o,        // subdata read value
  output logic      [7:0]           indirect_selector_o, // current selector
  // usb engine side
  input  wire usb_fap_pkg::sof_s    sof_i,          // start-of-frame event
  input  wire logic                 addr_load_i,    // host assigned address
  input  wire logic [6:0]           addr_value_i,   // address to load
  input  wire logic                 usb_reset_i,    // bus reset seen
  input  wire logic                 token_valid_i,  // token pulse
  input  wire usb_fap_pkg::token_s  token_i,        // token fields
  output logic                      token_accept_o, // token for this function
  output logic                      token_is_in_o,  // accepted token direction
  output logic      [3:0]           token_buf_o,    // buffer endpoint to use
  output logic      [10:0]          frame_count_o,  // current frame count
  output logic      [6:0]           function_address_o, // stored address
  output logic                      pair_out_two_three_o, // out pair on
  output logic                      pair_in_two_three_o   // in pair on
);

  // ===========================================================
  // reset synchroniser
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  // two-flop release of the async reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // ===========================================================
  // state
  logic [7:0]          sel_r;
  logic [FRAME_W-1:0]  frame_r;
  logic [ADDR_W-1:0]   faddr_r;
  logic                pair_out_r;
  logic                pair_in_r;
  logic [7:0]          rdata_r;
  logic [7:0]          rdata_nxt;
  logic                accept_r;
  logic                is_in_r;
  logic [ENDP_W-1:0]   buf_r;
  logic                addr_hit;
  logic [ENDP_W-1:0]   out_buf;
  logic [ENDP_W-1:0]   in_buf;

  // indirect selector register
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      sel_r <= SEL_RST;
    else if (sel_wr_i)
      sel_r <= wdata_i;
  end

  // frame count follows each start-of-frame only
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      frame_r <= FRAME_RST;                     // [RL10]
    else if (sof_i.valid)
      frame_r <= sof_i.frame;                   // [RL1]
  end

  // function address: set by the usb engine, never by the data port
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      faddr_r <= ADDR_RST;                      // [RL10]
    else if (usb_reset_i)
      faddr_r <= ADDR_RST;
    else if (addr_load_i)
      faddr_r <= addr_value_i;                  // [RL5]
  end

  // pairing controls, writable at their subaddress only
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pair_out_r <= PAIR_RST;                   // [RL10]
      pair_in_r  <= PAIR_RST;                   // [RL10]
    end
    else if (data_wr_i && (sel_r == SA_EP_PAIRING)) // [RL4]
    begin
      pair_out_r <= wdata_i[PAIR_OUT_BIT];      // [RL7]
      pair_in_r  <= wdata_i[PAIR_IN_BIT];       // [RL8]
    end
  end

  // ===========================================================
  // subdata read mux, reserved bits read as zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    case (sel_r)
      SA_FRAME_LOW:  rdata_nxt = frame_r[FRAME_LOW_W-1:0];        // [RL2] [RL3]
      SA_FRAME_HIGH: rdata_nxt = {5'h00, frame_r[FRAME_W-1:FRAME_LOW_W]}; // [RL2] [RL3]
      SA_FUNC_ADDR:  rdata_nxt = {1'b0, faddr_r};                 // [RL4] [RL5]
      SA_EP_PAIRING: rdata_nxt = {4'h0, pair_out_r, 2'h0, pair_in_r}; // [RL4] [RL9]
      default:       rdata_nxt = 8'h00;
    endcase
  end

  // read data captured on the read strobe, held until the next one
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= RDATA_RST;
    else if (data_rd_i)
      rdata_r <= rdata_nxt;
  end

  // ===========================================================
  // token filtering and buffer steering
  assign addr_hit = token_valid_i && (token_i.addr == faddr_r);  // [RL6]

  pair_steer u_out_steer (
    .clk_i     (ref_clk_i),
    .rst_n_i   (rst_n),
    .pair_en_i (pair_out_r),
    .hit_i     (addr_hit && !token_i.is_in),
    .endp_i    (token_i.endp),
    .buf_o     (out_buf)
  );

  pair_steer u_in_steer (
    .clk_i     (ref_clk_i),
    .rst_n_i   (rst_n),
    .pair_en_i (pair_in_r),
    .hit_i     (addr_hit && token_i.is_in),
    .endp_i    (token_i.endp),
    .buf_o     (in_buf)
  );

  // accept pulse one cycle after a matching token
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      accept_r <= 1'b0;
      is_in_r  <= 1'b0;
      buf_r    <= 4'h0;
    end
    else
    begin
      accept_r <= addr_hit;                     // [RL6]
      if (addr_hit)
      begin
        is_in_r <= token_i.is_in;
        buf_r   <= token_i.is_in ? in_buf : out_buf; // [RL7] [RL8]
      end
    end
  end

  // ===========================================================
  // outputs, all from flops
  assign rdata_o              = rdata_r;
  assign indirect_selector_o  = sel_r;
  assign token_accept_o       = accept_r;
  assign token_is_in_o        = is_in_r;
  assign token_buf_o          = buf_r;
  assign frame_count_o        = frame_r;
  assign function_address_o   = faddr_r;
  assign pair_out_two_three_o = pair_out_r;
  assign pair_in_two_three_o  = pair_in_r;

  // ===========================================================
  // checks
  a_frame_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RL1]
    sof_i.valid |=> frame_count_o == $past(sof_i.frame))
    else $error("frame count did not load sof number");

  a_frame_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RL1]
    !sof_i.valid |=> $stable(frame_count_o))
    else $error("frame count changed without sof");

  a_frame_low_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RL3]
    (data_rd_i && sel_r == SA_FRAME_LOW) |=> rdata_o == $past(frame_r[7:0]))
    else $error("frame low read mismatch");

  a_frame_high_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RL2]
    (data_rd_i && sel_r == SA_FRAME_HIGH)
      |=> rdata_o == {5'h00, $past(frame_r[10:8])})
    else $error("frame high read mismatch");

  a_addr_read_only: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RL5]
    (data_wr_i && !addr_load_i && !usb_reset_i) |=> $stable(function_address_o))
    else $error("function address changed by software write");

  a_addr_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RL4]
    (data_rd_i && sel_r == SA_FUNC_ADDR) |=> rdata_o == {1'b0, $past(faddr_r)})
    else $error("function address read mismatch");

  a_token_match: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RL6]
    (token_valid_i && token_i.addr == faddr_r) |=> token_accept_o)
    else $error("matching token not accepted");

  a_token_other: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RL6]
    !(token_valid_i && token_i.addr == faddr_r) |=> !token_accept_o)
    else $error("foreign token accepted");

  a_pair_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RL7]
    (data_wr_i && sel_r == SA_EP_PAIRING)
      |=> {pair_out_two_three_o, pair_in_two_three_o} == {$past(wdata_i[3]), $past(wdata_i[0])})
    else $error("pairing write not taken");

  a_pair_reserved: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RL9]
    (data_rd_i && sel_r == SA_EP_PAIRING) |=> (rdata_o & 8'hf6) == 8'h00)
    else $error("pairing reserved bits not zero");

  a_in_pair_steer: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [RL8]
    (addr_hit && token_i.is_in && pair_in_r && token_i.endp == EP_PAIR_HI)
      ##1 (addr_hit && token_i.is_in && pair_in_r && token_i.endp == EP_PAIR_HI)
      |=> token_buf_o != $past(token_buf_o))
    else $error("paired in tokens did not alternate");

endmodule // usb_frame_addr_pairing_regs
`default_nettype wire
